// [rtl/display_timing_pkg.sv]
`default_nettype none
package display_timing_pkg;
   // Register word offsets (byte addresses), one aligned word each
   localparam logic [5:0] OFF_H_START    = 6'h00;
   localparam logic [5:0] OFF_H_END      = 6'h04;
   localparam logic [5:0] OFF_V_START    = 6'h08;
   localparam logic [5:0] OFF_V_END      = 6'h0C;
   localparam logic [5:0] OFF_HSYNC_W    = 6'h10;
   localparam logic [5:0] OFF_LINE_PER   = 6'h14;
   localparam logic [5:0] OFF_VSYNC_ST   = 6'h18;
   localparam logic [5:0] OFF_FRAME_PER  = 6'h1C;
   localparam logic [5:0] OFF_BLANK_HI   = 6'h20;
   localparam logic [5:0] OFF_BLANK_LO   = 6'h24;
   localparam logic [5:0] OFF_MATCH_HI   = 6'h28;
   localparam logic [5:0] OFF_MATCH_LO   = 6'h2C;
   localparam logic [5:0] OFF_MODE       = 6'h30;
   localparam logic [5:0] OFF_STATUS     = 6'h34;

   // Field widths
   localparam int START_W = 9;
   localparam int END_W   = 10;
   localparam int HSW_W   = 7;
   localparam int LINE_W  = 11;
   localparam int VPOS_W  = 10;
   localparam int COMP_W  = 6;

   // Colour component positions
   localparam int COMP_HI_LSB = 2;
   localparam int COMP_G_LSB  = 10;

   // Sync mode encoding
   localparam logic [1:0] MODE_TV = 2'h2;

   // Status bit position
   localparam int STAT_TIMEOUT = 0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage
`default_nettype wire

// [rtl/display_timing_generator.sv]
// Function
// [RULE1] Horizontal window from programmed start/end dots
// [RULE2] Vertical window from programmed start/end lines
// [RULE3] Start fields 9 bits, end fields 10
// [RULE4] Hsync low for programmed dot count
// [RULE5] Line period from 11-bit cycle field
// [RULE6] Software: TV line period not below external
// [RULE7] Vsync starts at programmed line
// [RULE8] Software: internal vsync not before external
// [RULE9] Frame period equals programmed line count; the code runs one line more, lines 0 to the field value
// [RULE10] TV mode: flag missing external vsync rise
// [RULE11] Output blank colour while display off
// [RULE12] Blank colour field positions in two registers
// [RULE13] Colour detect when output equals match colour
// [RULE14] Software writes zero to reserved bits
// [RULE15] Timing and colour fields survive reset
// [RULE16] Display enable inside both windows
// [RULE17] Dot counter wraps, line counter advances
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`default_nettype none
module display_timing_generator
   import display_timing_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // AXI4-Lite write address
   input  wire logic [5:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [5:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // External sync pins
   input  wire logic        external_hsync_in,
   input  wire logic        external_vsync_in,
   // Pixel path
   input  wire logic [17:0] pixelIn,
   output logic [17:0]      pixelOut,
   output logic             hsyncOutB,
   output logic             vsyncOutB,
   output logic             displayEnable,
   output logic             color_match_out
);
   // Configuration, not reset on purpose, apart from mode and status
   logic [START_W-1:0] h_active_start_q;
   logic [START_W-1:0] v_active_start_q;
   logic [END_W-1:0]   h_active_end_q;
   logic [END_W-1:0]   v_active_end_q;
   logic [HSW_W-1:0]   hsync_width_field_q;
   logic [LINE_W-1:0]  line_period_field_q;
   logic [VPOS_W-1:0]  vsync_start_field_q;
   logic [VPOS_W-1:0]  frame_period_field_q;
   logic [COMP_W-1:0]  blank_red_q;
   logic [COMP_W-1:0]  blank_green_q;
   logic [COMP_W-1:0]  blank_blue_q;
   logic [COMP_W-1:0]  match_red_q;
   logic [COMP_W-1:0]  match_green_q;
   logic [COMP_W-1:0]  match_blue_q;
   logic [1:0]         syncMode_q;
   logic               timeoutFlag_q;

   // Bus state
   logic        awHeld_q;
   logic        wHeld_q;
   logic [5:0]  awAddr_q;
   logic [31:0] wData_q;
   logic [3:0]  wStrb_q;

   // Synchronisers
   // Not reset: the pins idle long before TV mode is selected
   logic [1:0] exHsSync_q;
   logic [1:0] exVsSync_q;
   logic       exHsPrev_q;
   logic       exVsPrev_q;

   // Timing state
   logic [LINE_W-1:0] dotCount_q;
   logic [VPOS_W-1:0] lineCount_q;
   logic [VPOS_W-1:0] waitLines_q;

   // Write channel
   wire awTake   = s_axi_awvalid && s_axi_awready;
   wire wTake    = s_axi_wvalid && s_axi_wready;
   wire haveAw   = awHeld_q || awTake;
   wire haveW    = wHeld_q || wTake;
   wire [5:0]  wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
   wire [31:0] wrData = wHeld_q ? wData_q : s_axi_wdata;
   wire [3:0]  wrStrb = wHeld_q ? wStrb_q : s_axi_wstrb;
   wire        doWrite = haveAw && haveW && !s_axi_bvalid;
   wire        wrLo    = doWrite && wrStrb[0];
   wire        wrHi    = doWrite && wrStrb[1];
   wire        wrMapped  = (wrAddr <= OFF_STATUS);
   wire        wrAligned = (wrAddr[1:0] == 2'h0);
   // Unmapped writes still answer, with an error and no effect
   wire        wrOk    = wrMapped && wrAligned;

   // Register write selects
   wire selHStart   = wrLo && (wrAddr == OFF_H_START);
   wire selHEnd     = wrLo && (wrAddr == OFF_H_END);
   wire selVStart   = wrLo && (wrAddr == OFF_V_START);
   wire selVEnd     = wrLo && (wrAddr == OFF_V_END);
   wire selHsWidth  = wrLo && (wrAddr == OFF_HSYNC_W);
   wire selLinePer  = wrLo && (wrAddr == OFF_LINE_PER);
   wire selVsStart  = wrLo && (wrAddr == OFF_VSYNC_ST);
   wire selFramePer = wrLo && (wrAddr == OFF_FRAME_PER);
   wire selBlankHi  = wrLo && (wrAddr == OFF_BLANK_HI);
   wire selBlankLoB = wrLo && (wrAddr == OFF_BLANK_LO);
   wire selBlankLoG = wrHi && (wrAddr == OFF_BLANK_LO);
   wire selMatchHi  = wrLo && (wrAddr == OFF_MATCH_HI);
   wire selMatchLoB = wrLo && (wrAddr == OFF_MATCH_LO);
   wire selMatchLoG = wrHi && (wrAddr == OFF_MATCH_LO);
   wire selMode     = wrLo && (wrAddr == OFF_MODE);
   wire clrTimeout  = wrLo && (wrAddr == OFF_STATUS) && wrData[STAT_TIMEOUT];

   // Sync inputs after two flops
   wire exHs = exHsSync_q[1];
   wire exVs = exVsSync_q[1];
   wire tvMode = (syncMode_q == MODE_TV);
   wire exHsFall = exHsPrev_q && !exHs;
   wire exVsRise = !exVsPrev_q && exVs;

   // [RULE5] Line period
   wire lineEnd  = (dotCount_q >= line_period_field_q);
   // [RULE9] Frame period
   wire frameEnd = (lineCount_q >= frame_period_field_q);
   // TV mode restarts the line at the external edge
   wire lineRestart = lineEnd || (tvMode && exHsFall);

   // [RULE1] Horizontal window
   wire hAct = (dotCount_q >= LINE_W'(h_active_start_q))
            && (dotCount_q < LINE_W'(h_active_end_q));
   // [RULE2] Vertical window
   wire vAct = (lineCount_q >= VPOS_W'(v_active_start_q))
            && (lineCount_q < v_active_end_q);
   // [RULE16] Both windows
   wire dispOn = hAct && vAct;
   // [RULE4] Hsync low width
   wire hsLow = (dotCount_q < LINE_W'(hsync_width_field_q));
   // [RULE7] Vsync from programmed line for one line
   wire vsLow = (lineCount_q == vsync_start_field_q);
   // [RULE11] Blank colour
   wire [17:0] pixNext = dispOn ? pixelIn
                        : {blank_red_q, blank_green_q, blank_blue_q};
   // [RULE13] Colour compare on driven output
   wire matchNext = (pixNext == {match_red_q, match_green_q, match_blue_q});
   // [RULE10] Timeout when wait reaches one frame period of lines
   wire waitOver = tvMode && (waitLines_q >= frame_period_field_q) && lineRestart;

   // Read mux, fed by the live read address input
   // Data is captured at the handshake, so it stands until rready
   logic [31:0] rdMux;
   always_comb
   begin
      rdMux = ZERO32;
      case (s_axi_araddr)
         // [RULE3] Field widths
         OFF_H_START:   rdMux[START_W-1:0] = h_active_start_q;
         OFF_H_END:     rdMux[END_W-1:0]   = h_active_end_q;
         OFF_V_START:   rdMux[START_W-1:0] = v_active_start_q;
         OFF_V_END:     rdMux[END_W-1:0]   = v_active_end_q;
         OFF_HSYNC_W:   rdMux[HSW_W-1:0]   = hsync_width_field_q;
         OFF_LINE_PER:  rdMux[LINE_W-1:0]  = line_period_field_q;
         OFF_VSYNC_ST:  rdMux[VPOS_W-1:0]  = vsync_start_field_q;
         OFF_FRAME_PER: rdMux[VPOS_W-1:0]  = frame_period_field_q;
         // [RULE12] Colour positions
         OFF_BLANK_HI:  rdMux[COMP_HI_LSB+:COMP_W] = blank_red_q;
         OFF_BLANK_LO:  rdMux = {16'h0000, blank_green_q, 2'h0, blank_blue_q, 2'h0};
         OFF_MATCH_HI:  rdMux[COMP_HI_LSB+:COMP_W] = match_red_q;
         OFF_MATCH_LO:  rdMux = {16'h0000, match_green_q, 2'h0, match_blue_q, 2'h0};
         OFF_MODE:      rdMux[1:0] = syncMode_q;
         OFF_STATUS:    rdMux[STAT_TIMEOUT] = timeoutFlag_q;
         default:       rdMux = ZERO32;
      endcase
   end
   wire rdMapped  = (s_axi_araddr <= OFF_STATUS);
   wire rdAligned = (s_axi_araddr[1:0] == 2'h0);
   wire rdOk      = rdMapped && rdAligned;

   // Bus handshake flops
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         awHeld_q      <= 1'b0;
         wHeld_q       <= 1'b0;
         awAddr_q      <= 6'h00;
         wData_q       <= ZERO32;
         wStrb_q       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= ZERO32;
         s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         if (awTake)
         begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (wTake)
         begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         s_axi_awready <= !haveAw && !s_axi_awready;
         s_axi_wready  <= !haveW && !s_axi_wready;
         if (doWrite)
         begin
            awHeld_q     <= 1'b0;
            wHeld_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrOk ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdMux;
            s_axi_rresp   <= rdOk ? RESP_OKAY : RESP_SLVERR;
         end
         else
         begin
            if (s_axi_rvalid && s_axi_rready)
               s_axi_rvalid <= 1'b0;
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         end
      end
   end

   // [RULE15] Configuration keeps its value through reset
   always_ff @(posedge clock)
   begin
      // Window fields
      if (selHStart)
         h_active_start_q <= wrData[START_W-1:0];
      if (selHEnd)
         h_active_end_q <= wrData[END_W-1:0];
      if (selVStart)
         v_active_start_q <= wrData[START_W-1:0];
      if (selVEnd)
         v_active_end_q <= wrData[END_W-1:0];
      // Sync and period fields
      if (selHsWidth)
         hsync_width_field_q <= wrData[HSW_W-1:0];
      if (selLinePer)
         line_period_field_q <= wrData[LINE_W-1:0];
      if (selVsStart)
         vsync_start_field_q <= wrData[VPOS_W-1:0];
      if (selFramePer)
         frame_period_field_q <= wrData[VPOS_W-1:0];
      // Colour fields, green rides on the upper byte strobe
      if (selBlankHi)
         blank_red_q <= wrData[COMP_HI_LSB+:COMP_W];
      if (selBlankLoB)
         blank_blue_q <= wrData[COMP_HI_LSB+:COMP_W];
      if (selBlankLoG)
         blank_green_q <= wrData[COMP_G_LSB+:COMP_W];
      if (selMatchHi)
         match_red_q <= wrData[COMP_HI_LSB+:COMP_W];
      if (selMatchLoB)
         match_blue_q <= wrData[COMP_HI_LSB+:COMP_W];
      if (selMatchLoG)
         match_green_q <= wrData[COMP_G_LSB+:COMP_W];
   end

   // Mode and status, reset normally
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         syncMode_q    <= 2'h0;
         timeoutFlag_q <= 1'b0;
      end
      else
      begin
         if (selMode)
            syncMode_q <= wrData[1:0];
         // [RULE10] Set wins over write-one-to-clear
         // A clear that meets a new timeout is lost; software rereads
         if (waitOver)
            timeoutFlag_q <= 1'b1;
         else if (clrTimeout)
            timeoutFlag_q <= 1'b0;
      end
   end

   // Pin synchronisers
   always_ff @(posedge clock)
   begin
      exHsSync_q <= {exHsSync_q[0], external_hsync_in};
      exVsSync_q <= {exVsSync_q[0], external_vsync_in};
      exHsPrev_q <= exHs;
      exVsPrev_q <= exVs;
   end

   // [RULE17] Dot and line counters
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         dotCount_q  <= '0;
         lineCount_q <= '0;
         waitLines_q <= '0;
      end
      else
      begin
         dotCount_q <= lineRestart ? '0 : dotCount_q + 1'b1;
         // External rise realigns the frame in TV mode
         if (tvMode && exVsRise)
            lineCount_q <= '0;
         else if (lineRestart)
            lineCount_q <= frameEnd ? '0 : lineCount_q + 1'b1;
         if (!tvMode || exVsRise || waitOver)
            waitLines_q <= '0;
         else if (lineRestart)
            waitLines_q <= waitLines_q + 1'b1;
      end
   end

   // Registered outputs
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         pixelOut        <= 18'h0_0000;
         hsyncOutB       <= 1'b1;
         vsyncOutB       <= 1'b1;
         displayEnable   <= 1'b0;
         color_match_out <= 1'b0;
      end
      else
      begin
         pixelOut        <= pixNext;
         hsyncOutB       <= !hsLow;
         vsyncOutB       <= !vsLow;
         displayEnable   <= dispOn;
         color_match_out <= matchNext;
      end
   end
endmodule
`default_nettype wire

// [tb/display_timing_sva.sv]
`default_nettype none
module display_timing_sva
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst_b,
   // Bus answers
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Video
   input wire logic [17:0] pixelIn,
   input wire logic [17:0] pixelOut,
   input wire logic        hsyncOutB,
   input wire logic        vsyncOutB,
   input wire logic        displayEnable
);
   timeunit 1ns;
   timeprecision 100ps;
   // Bench timing: 20 dots a line, 6 lines a frame
   localparam int LINE = 20;
   localparam int FRAME = 120;
   logic armed_q = 1'b0;
   // Fields are X until written; arm at the reset that follows setup
   always_ff @(posedge clock)
   begin
      if (!rst_b && $time > 500)
         armed_q <= 1'b1;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   a_read_answer:
      assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer");
   a_pixel_pass:
      assert property (armed_q && displayEnable |-> pixelOut == $past(pixelIn)) else $error("pass");
   a_blank_steady:
      assert property (armed_q && $past(rst_b) && $past(rst_b, 2) && !displayEnable
         && !$past(displayEnable)
         |-> $stable(pixelOut)) else $error("blank colour");
   a_hsync_width:
      assert property (armed_q && $fell(hsyncOutB) |-> !hsyncOutB[*3] ##1 hsyncOutB)
         else $error("hsync width");
   a_line_period:
      assert property (armed_q && $fell(hsyncOutB) |-> ##LINE $fell(hsyncOutB))
         else $error("line period");
   a_frame_period:
      assert property (armed_q && $fell(vsyncOutB) |-> ##FRAME $fell(vsyncOutB))
         else $error("frame period");
   a_window_width:
      assert property (armed_q && $rose(displayEnable) |-> displayEnable[*8] ##1 !displayEnable)
         else $error("window width");
   a_vsync_start:
      assert property (armed_q && $fell(vsyncOutB) |-> $fell(hsyncOutB)) else $error("vsync");
endmodule
`default_nettype wire

// [tb/panel_model.sv]
`default_nettype none
module panel_model
(
   // Video from the generator
   input  wire logic        clock,
   input  wire logic        vsyncOutB,
   input  wire logic        displayEnable,
   input  wire logic        color_match_out,
   input  wire logic [17:0] pixelOut,
   // Tallies of the last whole frame
   output logic [7:0]       activeCount,
   output logic [7:0]       matchCount,
   output logic [17:0]      blankSample
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] activeRun = 8'h00;
   logic [7:0] matchRun  = 8'h00;
   logic       vsyncPrev = 1'b1;
   wire        frameEdge = vsyncPrev && !vsyncOutB;
   // Vsync fall lies outside the window, so the sample is blank colour
   always @(posedge clock)
   begin
      vsyncPrev <= vsyncOutB;
      if (frameEdge)
      begin
         activeCount <= activeRun;
         matchCount  <= matchRun;
         blankSample <= pixelOut;
      end
      activeRun <= (frameEdge ? 8'h00 : activeRun) + {7'h00, displayEnable};
      matchRun  <= (frameEdge ? 8'h00 : matchRun) + {7'h00, color_match_out};
   end
endmodule
`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
module testbench
   import display_timing_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] WIDEST [12] = '{16'h01FF, 16'h03FF, 16'h01FF, 16'h03FF, 16'h007F,
      16'h07FF, 16'h03FF, 16'h03FF, 16'h00FC, 16'hFCFC, 16'h00FC, 16'hFCFC};
   localparam logic [15:0] SETUP [12] = '{16'h0004, 16'h000C, 16'h0001, 16'h0003, 16'h0003,
      16'h0013, 16'h0004, 16'h0005, 16'h0054, 16'hA83C, 16'h0054, 16'hA83C};
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   // External sync idles high, never outpacing the programmed timing
   logic        external_hsync_in = 1'b1, external_vsync_in = 1'b1;
   logic [17:0] pixelIn = {6'h01, 6'h02, 6'h03};
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [17:0] pixelOut, blankSample;
   logic        hsyncOutB, vsyncOutB, displayEnable, color_match_out;
   logic [7:0]  activeCount, matchCount;
   int          mismatches = 0, comparisons = 0, cycles = 0;
   display_timing_generator u_dut (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .external_hsync_in, .external_vsync_in, .pixelIn, .pixelOut,
      .hsyncOutB, .vsyncOutB, .displayEnable, .color_match_out);
   panel_model u_panel (.clock, .vsyncOutB, .displayEnable, .color_match_out, .pixelOut,
      .activeCount, .matchCount, .blankSample);
   always #2.5 clock = ~clock;
   task automatic end_of_test();
      if (mismatches == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      check({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      check(s_axi_rdata, e);
      check({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   initial
   begin
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < 12; i++)
      begin
         wr(6'(4 * i), {16'h0000, WIDEST[i]}, RESP_OKAY);
         rd(6'(4 * i), {16'h0000, WIDEST[i]}, RESP_OKAY);
      end
      wr(6'h38, 32'h0000_0001, RESP_SLVERR);
      rd(6'h3C, ZERO32, RESP_SLVERR);
      // Setup words keep reserved bits at zero
      for (int i = 0; i < 12; i++)
         wr(6'(4 * i), {16'h0000, SETUP[i]}, RESP_OKAY);
      rst_b <= 1'b0;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < 12; i++)
         rd(6'(4 * i), {16'h0000, SETUP[i]}, RESP_OKAY);
      repeat (300) @(posedge clock);
      check({24'h00_0000, activeCount}, 32'h0000_0010);
      check({24'h00_0000, matchCount}, 32'h0000_0068);
      check({14'h0000, blankSample}, {14'h0000, 6'h15, 6'h2A, 6'h0F});
      wr(OFF_MATCH_HI, 32'h0000_0004, RESP_OKAY);
      wr(OFF_MATCH_LO, 32'h0000_080C, RESP_OKAY);
      repeat (300) @(posedge clock);
      check({24'h00_0000, matchCount}, 32'h0000_0010);
      wr(OFF_MODE, {30'h0, MODE_TV}, RESP_OKAY);
      repeat (400) @(posedge clock);
      rd(OFF_STATUS, 32'h0000_0001, RESP_OKAY);
      // Leave TV mode first so no new timeout races the clear
      wr(OFF_MODE, ZERO32, RESP_OKAY);
      wr(OFF_STATUS, 32'h0000_0001, RESP_OKAY);
      rd(OFF_STATUS, ZERO32, RESP_OKAY);
      end_of_test();
   end
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         mismatches++;
         $display("[ERR] %0t timeout", $time);
         end_of_test();
      end
   end
endmodule
bind display_timing_generator display_timing_sva u_sva (.clock, .rst_b, .s_axi_rvalid,
   .s_axi_rready, .pixelIn, .pixelOut, .hsyncOutB, .vsyncOutB, .displayEnable);
`default_nettype wire
